/* File: rtl/wdt_defines.svh */
// Register map, field positions and reset values of the watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

`define WDT_ADDR_W        6
`define WDT_OFS_RELOAD    6'h00
`define WDT_OFS_VALUE     6'h04
`define WDT_OFS_CTRL      6'h08
`define WDT_OFS_INTCLR    6'h0C
`define WDT_OFS_RIS       6'h10
`define WDT_OFS_MIS       6'h14
`define WDT_OFS_LOCK      6'h18
`define WDT_OFS_STATUS    6'h1C

`define WDT_CTRL_INTEN    0
`define WDT_CTRL_RESEN    1
`define WDT_CTRL_NMI      2
`define WDT_CTRL_STALL    3

`define WDT_STAT_RUN      0
`define WDT_STAT_LOCK     1

`define WDT_UNLOCK_KEY    32'h1ACC_E551
`define WDT_RELOAD_RST    32'hFFFF_FFFF
`define WDT_ZERO32        32'h0000_0000

`endif

/* File: rtl/wdt_pkg.sv */
// Types shared by the watchdog design
package wdt_pkg;
    typedef logic [31:0] wdt_word_t;
    typedef logic [5:0]  wdt_addr_t;
    typedef enum logic [1:0] {
        WDT_IDLE  = 2'b00,
        WDT_ARMED = 2'b01,
        WDT_FIRED = 2'b11
    } wdt_state_e;
endpackage

/* File: rtl/wdt_timer.sv */
// Watchdog timer with Avalon-MM register slave
`include "wdt_defines.svh"

// Notes on behaviour
// - 32-bit down counter, reload, interrupt, lock
// - First zero raises interrupt, reloads, continues
// - Zero while pending is second timeout
// - Starting counter also enables interrupt
// - Interrupt clear drops the request
// - Software-settable interrupt enable
// - Raw and masked interrupt state readable
// - Status bit one once interrupt enabled
// - Type selects standard or non-maskable output
// - Enable still gates non-maskable request
// - Lock blocks configuration writes until unlocked
// - Locked writes leave enable, reload, reset
// - Lock status readable
// - Unlock restores write access
// - Reload register reads back
// - Reload write while running reloads counter
// - Reload of zero while armed raises interrupt at once
// - Reset enable gates second-timeout reset
// - Running indication after enable
// - Stall holds count during debug halt
// - Without stall, count ignores debug state
// - Counter value readable any time
module wdt_timer (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    // Avalon-MM slave
    input  wire wdt_pkg::wdt_addr_t avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire wdt_pkg::wdt_word_t avs_writedata,
    output logic [31:0]          avs_readdata,
    output logic                 avs_waitrequest,
    // Processor side
    input  wire logic            debugHalt,
    output logic                 wdtIrq,
    output logic                 wdtNmi,
    output logic                 wdtReset
);
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, answer on the second edge
    logic       ackPending_r;
    logic       accept;
    wdt_word_t  rdMux;

    assign accept = (avs_read || avs_write) && ackPending_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ackPending_r <= 1'b0;
        end else if (accept) begin
            ackPending_r <= 1'b0;
        end else begin
            ackPending_r <= avs_read || avs_write;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ackPending_r);
        end
    end

    function automatic logic hit(input wdt_addr_t a, input wdt_addr_t ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Debug halt pin synchroniser
    logic [2:0] haltSync_r;
    logic       haltSeen_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            haltSync_r <= 3'b000;
        end else begin
            haltSync_r <= {haltSync_r[1:0], debugHalt};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            haltSeen_r <= 1'b0;
        end else if (haltSync_r[1] == haltSync_r[2]) begin
            haltSeen_r <= haltSync_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    logic wrReload, wrCtrl, wrClr, wrLock;
    logic locked_r;

    assign wrReload = accept && avs_write && !locked_r
                    && hit(avs_address, `WDT_OFS_RELOAD);
    assign wrCtrl   = accept && avs_write && !locked_r
                    && hit(avs_address, `WDT_OFS_CTRL);
    assign wrClr    = accept && avs_write && !locked_r
                    && hit(avs_address, `WDT_OFS_INTCLR);
    assign wrLock   = accept && avs_write
                    && hit(avs_address, `WDT_OFS_LOCK);

    // Lock: key unlocks, any other value locks
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            locked_r <= 1'b0;
        end else if (wrLock) begin
            locked_r <= (avs_writedata != `WDT_UNLOCK_KEY);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration
    wdt_word_t reload_value_r;
    logic      intEn_r, resEn_r, nmiSel_r, stallEn_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reload_value_r <= `WDT_RELOAD_RST;
        end else if (wrReload) begin
            reload_value_r <= avs_writedata;
        end
    end

    // Interrupt enable is sticky once set: it starts the counter too
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            intEn_r   <= 1'b0;
            resEn_r   <= 1'b0;
            nmiSel_r  <= 1'b0;
            stallEn_r <= 1'b0;
        end else if (wrCtrl) begin
            intEn_r   <= intEn_r | avs_writedata[`WDT_CTRL_INTEN];
            resEn_r   <= avs_writedata[`WDT_CTRL_RESEN];
            nmiSel_r  <= avs_writedata[`WDT_CTRL_NMI];
            stallEn_r <= avs_writedata[`WDT_CTRL_STALL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and timeout state machine
    wdt_word_t  count_r;
    wdt_state_e state_r;
    logic       tick, zeroHit, rawInt, secondTo;

    assign tick    = intEn_r && !(stallEn_r && haltSeen_r);
    assign zeroHit = tick && (count_r == `WDT_ZERO32);
    assign rawInt  = (state_r == WDT_FIRED);
    assign secondTo = zeroHit && rawInt;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= `WDT_RELOAD_RST;
        end else if (wrReload) begin
            count_r <= avs_writedata;
        end else if (zeroHit) begin
            count_r <= reload_value_r;
        end else if (tick) begin
            count_r <= count_r - 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= WDT_IDLE;
        end else begin
            case (state_r)
                WDT_IDLE: begin
                    if (wrCtrl && avs_writedata[`WDT_CTRL_INTEN]) begin
                        state_r <= WDT_ARMED;
                    end
                end
                WDT_ARMED: begin
                    if (zeroHit || (wrReload
                        && avs_writedata == `WDT_ZERO32)) begin
                        state_r <= WDT_FIRED;
                    end
                end
                WDT_FIRED: begin
                    // A timeout in the clear cycle keeps it pending
                    if (wrClr && !zeroHit) begin
                        state_r <= WDT_ARMED;
                    end
                end
                default: begin
                    state_r <= WDT_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wdtIrq   <= 1'b0;
            wdtNmi   <= 1'b0;
            wdtReset <= 1'b0;
        end else begin
            wdtIrq   <= rawInt && intEn_r && !nmiSel_r && !wrClr;
            wdtNmi   <= rawInt && intEn_r && nmiSel_r && !wrClr;
            wdtReset <= secondTo && resEn_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdMux = `WDT_ZERO32;
        if (hit(avs_address, `WDT_OFS_RELOAD)) begin
            rdMux = reload_value_r;
        end else if (hit(avs_address, `WDT_OFS_VALUE)) begin
            rdMux = count_r;
        end else if (hit(avs_address, `WDT_OFS_CTRL)) begin
            rdMux[`WDT_CTRL_INTEN] = intEn_r;
            rdMux[`WDT_CTRL_RESEN] = resEn_r;
            rdMux[`WDT_CTRL_NMI]   = nmiSel_r;
            rdMux[`WDT_CTRL_STALL] = stallEn_r;
        end else if (hit(avs_address, `WDT_OFS_RIS)) begin
            rdMux[0] = rawInt;
        end else if (hit(avs_address, `WDT_OFS_MIS)) begin
            rdMux[0] = rawInt && intEn_r;
        end else if (hit(avs_address, `WDT_OFS_LOCK)) begin
            rdMux[0] = locked_r;
        end else if (hit(avs_address, `WDT_OFS_STATUS)) begin
            rdMux[`WDT_STAT_RUN]  = (state_r != WDT_IDLE);
            rdMux[`WDT_STAT_LOCK] = locked_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= `WDT_ZERO32;
        end else if (avs_read && !ackPending_r) begin
            avs_readdata <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_reload_load;
        @(posedge sys_clk) disable iff (!reset_n)
        wrReload |=> count_r == $past(avs_writedata);
    endproperty
    a_reload_load: assert property (p_reload_load)
        else $error("Reload write did not load counter");

    property p_zero_fire;
        @(posedge sys_clk) disable iff (!reset_n)
        zeroHit && !wrReload && state_r == WDT_ARMED
            |=> rawInt && count_r == $past(reload_value_r);
    endproperty
    a_zero_fire: assert property (p_zero_fire)
        else $error("First timeout did not fire and reload");

    property p_reset_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        wdtReset |-> $past(resEn_r) && $past(rawInt);
    endproperty
    a_reset_gate: assert property (p_reset_gate)
        else $error("Reset without enable or pending interrupt");

    property p_second;
        @(posedge sys_clk) disable iff (!reset_n)
        secondTo && resEn_r |=> wdtReset;
    endproperty
    a_second: assert property (p_second)
        else $error("Second timeout gave no reset");

    property p_locked;
        @(posedge sys_clk) disable iff (!reset_n)
        locked_r && accept && avs_write && !hit(avs_address, `WDT_OFS_LOCK)
            |=> $stable(reload_value_r) && $stable(resEn_r);
    endproperty
    a_locked: assert property (p_locked)
        else $error("Reload changed while locked");

    property p_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        wrClr && !zeroHit && rawInt |=> !rawInt ##1 !wdtIrq && !wdtNmi;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Clear did not drop interrupt");

    property p_stall;
        @(posedge sys_clk) disable iff (!reset_n)
        stallEn_r && haltSeen_r && !wrReload |=> $stable(count_r);
    endproperty
    a_stall: assert property (p_stall)
        else $error("Counter moved during debug stall");

    property p_irq_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        (wdtIrq || wdtNmi) |-> $past(intEn_r) && !(wdtIrq && wdtNmi);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt without enable");

    property p_enable;
        @(posedge sys_clk) disable iff (!reset_n)
        wrCtrl && avs_writedata[`WDT_CTRL_INTEN] |=> intEn_r
            && state_r != WDT_IDLE;
    endproperty
    a_enable: assert property (p_enable)
        else $error("Enable did not start timer");

    property p_wait_one;
        @(posedge sys_clk) disable iff (!reset_n)
        (avs_read || avs_write) && !ackPending_r |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("Request got no answer after one wait state");

    property p_wait_short;
        @(posedge sys_clk) disable iff (!reset_n)
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_short: assert property (p_wait_short)
        else $error("Waitrequest low for more than one cycle");

    property p_lock_key;
        @(posedge sys_clk) disable iff (!reset_n)
        wrLock |=> locked_r == ($past(avs_writedata) != `WDT_UNLOCK_KEY);
    endproperty
    a_lock_key: assert property (p_lock_key)
        else $error("Lock write gave wrong lock state");

    property p_zero_reload;
        @(posedge sys_clk) disable iff (!reset_n)
        wrReload && avs_writedata == `WDT_ZERO32 && state_r == WDT_ARMED
            |=> rawInt;
    endproperty
    a_zero_reload: assert property (p_zero_reload)
        else $error("Zero reload did not raise interrupt");

    property p_no_reset;
        @(posedge sys_clk) disable iff (!reset_n)
        !resEn_r |=> !wdtReset;
    endproperty
    a_no_reset: assert property (p_no_reset)
        else $error("Reset issued while reset enable clear");

    property p_free_run;
        @(posedge sys_clk) disable iff (!reset_n)
        intEn_r && !stallEn_r && !wrReload && !zeroHit
            |=> count_r == $past(count_r) - 32'h0000_0001;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("Counter did not decrement without stall");

    property p_ris_read;
        @(posedge sys_clk) disable iff (!reset_n)
        avs_read && !ackPending_r && hit(avs_address, `WDT_OFS_RIS)
            |=> avs_readdata[0] == $past(rawInt);
    endproperty
    a_ris_read: assert property (p_ris_read)
        else $error("Raw status read wrong");

    property p_lock_read;
        @(posedge sys_clk) disable iff (!reset_n)
        avs_read && !ackPending_r && hit(avs_address, `WDT_OFS_LOCK)
            |=> avs_readdata[0] == $past(locked_r);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("Lock status read wrong");

    c_fire:   cover property (@(posedge sys_clk) rawInt);
    c_reset:  cover property (@(posedge sys_clk) wdtReset);
    c_nmi:    cover property (@(posedge sys_clk) wdtNmi);
    c_locked: cover property (@(posedge sys_clk) locked_r && wrLock);
endmodule // wdt_timer

/* File: tb/testbench.sv */
// Self-checking testbench for the watchdog timer
`include "wdt_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    logic        sys_clk;
    logic        reset_n;
    wdt_addr_t   avs_address;
    logic        avs_read;
    logic        avs_write;
    wdt_word_t   avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        debugHalt;
    logic        wdtIrq;
    logic        wdtNmi;
    logic        wdtReset;
    logic [2:0]  pins;
    int          n_mismatch;
    int          tests_run;
    integer      seed;
    wdt_word_t   rd;
    wdt_word_t   x;
    wdt_word_t   a;
    // Behavioural model of the software-visible configuration
    int unsigned mReload;
    bit          mLocked;
    bit          mRun;

    assign pins = {wdtReset, wdtNmi, wdtIrq};

    wdt_timer dut (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .debugHalt       (debugHalt),
        .wdtIrq          (wdtIrq),
        .wdtNmi          (wdtNmi),
        .wdtReset        (wdtReset)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input wdt_word_t got, input wdt_word_t exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    // One Avalon cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input wdt_addr_t ad,
                       input wdt_word_t d, output wdt_word_t q);
        @(posedge sys_clk);
        avs_address   <= ad;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input wdt_addr_t ad, input wdt_word_t d);
        wdt_word_t q;
        bus(1'b1, ad, d, q);
        if (ad == `WDT_OFS_LOCK) begin
            mLocked = (d != `WDT_UNLOCK_KEY);
        end else if (!mLocked && ad == `WDT_OFS_RELOAD) begin
            mReload = d;
        end else if (!mLocked && ad == `WDT_OFS_CTRL && d[0]) begin
            mRun = 1'b1;
        end
    endtask

    // Compare reload, lock and running state with the model
    task automatic chk_model;
        rdchk(`WDT_OFS_RELOAD, mReload);
        rdchk(`WDT_OFS_LOCK, 32'(mLocked));
        rdchk(`WDT_OFS_STATUS, 32'({mLocked, mRun}));
    endtask

    task automatic rdchk(input wdt_addr_t ad, input wdt_word_t exp);
        bus(1'b0, ad, 32'h0000_0000, rd);
        chk_word(rd, exp);
    endtask

    // Bounded watch of one output pin
    task automatic wait_pin(input int which, input int lim, input logic exp);
        logic seen;
        int   n;
        seen = 1'b0;
        n = 0;
        while (n < lim && !seen) begin
            @(posedge sys_clk);
            n++;
            if (pins[which] === 1'b1) seen = 1'b1;
        end
        chk_flag(seen, exp);
    endtask

    task automatic do_reset;
        mReload = `WDT_RELOAD_RST;
        mLocked = 1'b0;
        mRun = 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        debugHalt = 1'b0;
        reset_n = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        seed = 32'h7e8f_e1cd;
        do_reset;
        rdchk(`WDT_OFS_RELOAD, `WDT_RELOAD_RST);
        chk_model;
        rdchk(`WDT_OFS_STATUS, 32'h0000_0000);
        rdchk(`WDT_OFS_RIS, 32'h0000_0000);
        rdchk(6'h20, 32'h0000_0000);
        repeat (6) begin
            x = $random(seed);
            wr(`WDT_OFS_RELOAD, x);
            rdchk(`WDT_OFS_RELOAD, x);
        end
        // First timeout, clear, second timeout with and without reset
        wr(`WDT_OFS_RELOAD, 32'h0000_001E);
        wr(`WDT_OFS_CTRL, 32'h0000_0001);
        rdchk(`WDT_OFS_STATUS, 32'h0000_0001);
        wait_pin(0, 80, 1'b1);
        rdchk(`WDT_OFS_RIS, 32'h0000_0001);
        rdchk(`WDT_OFS_MIS, 32'h0000_0001);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, rd);
        chk_flag(rd <= 32'h0000_001E, 1'b1);
        wr(`WDT_OFS_INTCLR, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk_flag(wdtIrq, 1'b0);
        wait_pin(2, 100, 1'b0);
        wr(`WDT_OFS_CTRL, 32'h0000_0003);
        wait_pin(2, 80, 1'b1);
        // Reload while running, stall on debug halt
        x = 32'h0000_0100 + ($random(seed) & 32'h0000_00FF);
        wr(`WDT_OFS_RELOAD, x);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, rd);
        chk_flag(rd <= x && rd + 32'h0000_000A >= x, 1'b1);
        wr(`WDT_OFS_RELOAD, 32'h0000_03E8);
        wr(`WDT_OFS_CTRL, 32'h0000_0009);
        debugHalt <= 1'b1;
        repeat (8) @(posedge sys_clk);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, a);
        repeat (10) @(posedge sys_clk);
        rdchk(`WDT_OFS_VALUE, a);
        debugHalt <= 1'b0;
        repeat (8) @(posedge sys_clk);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, a);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, rd);
        chk_flag(rd < a, 1'b1);
        wr(`WDT_OFS_CTRL, 32'h0000_0001);
        wr(`WDT_OFS_RELOAD, 32'h0000_03E8);
        debugHalt <= 1'b1;
        repeat (8) @(posedge sys_clk);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, a);
        bus(1'b0, `WDT_OFS_VALUE, 32'h0000_0000, rd);
        chk_flag(rd < a, 1'b1);
        debugHalt <= 1'b0;
        wr(`WDT_OFS_INTCLR, 32'h0000_0000);
        rdchk(`WDT_OFS_RIS, 32'h0000_0000);
        wr(`WDT_OFS_RELOAD, 32'h0000_0000);
        rdchk(`WDT_OFS_RIS, 32'h0000_0001);
        // Lock, refused writes, unlock, then non-maskable routing
        do_reset;
        wr(`WDT_OFS_RELOAD, 32'h0000_0032);
        wr(`WDT_OFS_LOCK, $random(seed) & 32'h0000_FFFF);
        rdchk(`WDT_OFS_LOCK, 32'h0000_0001);
        rdchk(`WDT_OFS_STATUS, 32'h0000_0002);
        wr(`WDT_OFS_RELOAD, 32'h0000_004D);
        rdchk(`WDT_OFS_RELOAD, 32'h0000_0032);
        wr(`WDT_OFS_CTRL, 32'h0000_0003);
        rdchk(`WDT_OFS_STATUS, 32'h0000_0002);
        chk_model;
        wait_pin(0, 80, 1'b0);
        wr(`WDT_OFS_LOCK, `WDT_UNLOCK_KEY);
        rdchk(`WDT_OFS_LOCK, 32'h0000_0000);
        wr(`WDT_OFS_RELOAD, 32'h0000_0028);
        rdchk(`WDT_OFS_RELOAD, 32'h0000_0028);
        chk_model;
        chk_flag(wdtNmi, 1'b0);
        wr(`WDT_OFS_CTRL, 32'h0000_0005);
        wait_pin(1, 80, 1'b1);
        chk_flag(wdtIrq, 1'b0);
        wr(`WDT_OFS_INTCLR, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk_flag(wdtNmi, 1'b0);
        tally_and_finish;
    end
endmodule // testbench
